/* rtl/dram_ctrl_pkg.sv */
package dram_ctrl_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ROW_COUNT      = 256;
  localparam int ADDR_WIDTH     = 8;
  localparam int DATA_WIDTH     = 4;
  localparam int INIT_REFRESHES = 8;

  // ----------------------------------------------------------------
  // timing, fastest grade, in ns and us
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 20;
  localparam int POWER_UP_US       = 500;
  localparam int REFRESH_PERIOD_NS = 4000000;
  localparam int CYCLE_NS          = 200;
  localparam int PRECHARGE_NS      = 90;
  localparam int ROW_HOLD_NS       = 20;
  localparam int COL_DELAY_NS      = 40;
  localparam int CAS_PULSE_NS      = 60;
  localparam int TEST_RAS_NS       = 285;
  localparam int TEST_CYCLE_NS     = 385;

  // ----------------------------------------------------------------
  // derived counts: least times rounded up, refresh interval per row rounded down
  // ----------------------------------------------------------------
  localparam int POWER_UP_CYC  = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC   = REFRESH_PERIOD_NS / CLK_PERIOD_NS / ROW_COUNT;
  localparam int CYCLE_CYC     = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_HOLD_CYC  = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_DELAY_CYC = (COL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_PULSE_CYC = (CAS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TEST_RAS_CYC  = (TEST_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TEST_CYC      = (TEST_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    cmd_read       = 2'h0,
    cmd_write      = 2'h1,
    cmd_test_write = 2'h2,
    cmd_test_read  = 2'h3
  } command_type;

  typedef enum logic [6:0] {
    st_power  = 7'h01,
    st_idle   = 7'h02,
    st_row    = 7'h04,
    st_col    = 7'h08,
    st_cbr    = 7'h10,
    st_cbr_ras = 7'h20,
    st_pre    = 7'h40
  } state_type;

endpackage : dram_ctrl_pkg

/* rtl/cycle_timer.sv */
`timescale 1ns/10ps
module cycle_timer
  import dram_ctrl_pkg::*;
#(
  parameter int WIDTH = 20
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o
);
  logic [WIDTH-1:0] remain;

  // loads count-1 so done rises exactly count cycles after load
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= count_i - WIDTH'(1);
    end else if (remain != '0) begin
      remain <= remain - WIDTH'(1);
    end
  end

  assign done_o = (remain == '0) && !load_i;
endmodule : cycle_timer

/* rtl/dram_host_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - row then column address on eight shared pins, row strobe then column strobe
// - controller refreshes all 256 rows within every 4 ms
// - wait 500 us after power-on, then 8 refresh cycles before access
// - random cycles spaced at least the minimum cycle time
// - write strobe low before column strobe falls gives an early write; the controller drops write strobe on the same edge as column strobe
// - output-enable hold applies only to late write cycles
// - after a read, hold read command past column or row strobe rise
// - device drives data only under output enable; early write leaves it off
// - counter test keeps row strobe low the extended pulse width
// - counter test cycles spaced by the extended test cycle time
// - test step one writes zero to 256 counter rows at one column
// - test step two reads back zero with external row addresses
// - then writes one to those rows with external addresses
// - final step reads one through counter test cycles
module dram_host_ctrl
  import dram_ctrl_pkg::*;
#(
  parameter int POWER_UP_COUNT = POWER_UP_CYC,
  parameter int REFRESH_COUNT  = REFRESH_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  req_valid_i,
  input  wire command_type           req_cmd_i,
  input  wire logic [2*ADDR_WIDTH-1:0] req_addr_i,
  input  wire logic [DATA_WIDTH-1:0] req_wdata_i,
  output logic                       req_ready_o,
  output logic                       rsp_valid_o,
  output logic [DATA_WIDTH-1:0]      rsp_rdata_o,
  output logic                       init_done_o,
  output logic [ADDR_WIDTH-1:0]      multiplexed_address_o,
  output logic                       row_strobe_n_o,
  output logic                       col_strobe_n_o,
  output logic                       write_n_o,
  output logic                       out_enable_n_o,
  input  wire logic [DATA_WIDTH-1:0] data_lines_i,
  output logic [DATA_WIDTH-1:0]      data_lines_o,
  output logic                       data_lines_oe_o
);
  localparam int TW = 20;
  // test column phase tops the row strobe up to the extended test width
  localparam int TEST_COL_CYC = TEST_RAS_CYC - CYCLE_CYC + PRECHARGE_CYC - ROW_HOLD_CYC - 2;

  state_type         state;
  command_type       cmd;
  logic [2*ADDR_WIDTH-1:0] addr;
  logic [DATA_WIDTH-1:0]   wdata;
  logic              is_write;
  logic              is_test;
  logic              refresh_due;
  logic [3:0]        init_left;
  logic [TW-1:0]     refresh_cnt;
  logic              timer_load;
  logic [TW-1:0]     timer_count;
  logic              timer_done;
  logic [DATA_WIDTH-1:0] data_meta;
  logic [DATA_WIDTH-1:0] data_sync;

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= data_lines_i;
      data_sync <= data_meta;
    end
  end

  // ----------------------------------------------------------------
  // refresh interval: one row every REFRESH_COUNT cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refresh_cnt <= '0;
      refresh_due <= 1'b0;
    end else begin
      if (refresh_cnt == TW'(REFRESH_COUNT - 1)) begin
        refresh_cnt <= '0;
      end else begin
        refresh_cnt <= refresh_cnt + TW'(1);
      end
      // set wins over the clear taken when the refresh starts
      if (refresh_cnt == TW'(REFRESH_COUNT - 1)) begin
        refresh_due <= 1'b1;
      end else if (state == st_cbr) begin
        refresh_due <= 1'b0;
      end
    end
  end

  cycle_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .load_i    (timer_load),
    .count_i   (timer_count),
    .done_o    (timer_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state       <= st_power;
      cmd         <= cmd_read;
      addr        <= '0;
      wdata       <= '0;
      init_left   <= 4'(INIT_REFRESHES);
      timer_load  <= 1'b1;
      timer_count <= TW'(POWER_UP_COUNT);
      is_write    <= 1'b0;
      is_test     <= 1'b0;
    end else begin
      timer_load <= 1'b0;
      case (state)
        st_power: begin
          if (timer_done && !timer_load) begin
            state <= st_idle;
          end
        end
        st_idle: begin
          if (timer_done && !timer_load) begin
            if (refresh_due || init_left != 4'h0) begin
              state       <= st_cbr;
              is_test     <= 1'b0;
              is_write    <= 1'b0;
              timer_count <= TW'(1);
              timer_load  <= 1'b1;
            end else if (req_valid_i) begin
              cmd      <= req_cmd_i;
              addr     <= req_addr_i;
              wdata    <= req_wdata_i;
              is_write <= (req_cmd_i == cmd_write) || (req_cmd_i == cmd_test_write);
              is_test  <= (req_cmd_i == cmd_test_write) || (req_cmd_i == cmd_test_read);
              if ((req_cmd_i == cmd_test_write) || (req_cmd_i == cmd_test_read)) begin
                state       <= st_cbr;
                timer_count <= TW'(1);
              end else begin
                state       <= st_row;
                timer_count <= TW'(ROW_HOLD_CYC);
              end
              timer_load <= 1'b1;
            end
          end
        end
        st_row: begin
          if (timer_done && !timer_load) begin
            state       <= st_col;
            // one spare cycle keeps the capture clear of the access limit
            timer_count <= is_test ? TW'(TEST_COL_CYC) : TW'(CAS_PULSE_CYC + COL_DELAY_CYC + 1);
            timer_load  <= 1'b1;
          end
        end
        st_cbr: begin
          if (timer_done && !timer_load) begin
            state       <= st_cbr_ras;
            timer_count <= TW'(CYCLE_CYC - PRECHARGE_CYC);
            timer_load  <= 1'b1;
          end
        end
        st_cbr_ras: begin
          if (timer_done && !timer_load) begin
            state <= is_test ? st_row : st_pre;
            if (!is_test && init_left != 4'h0) begin
              init_left <= init_left - 4'h1;
            end
            timer_count <= is_test ? TW'(ROW_HOLD_CYC) : TW'(PRECHARGE_CYC);
            timer_load  <= 1'b1;
          end
        end
        st_col: begin
          if (timer_done && !timer_load) begin
            state       <= st_pre;
            timer_count <= is_test ? TW'(TEST_CYC - TEST_RAS_CYC) : TW'(PRECHARGE_CYC);
            timer_load  <= 1'b1;
          end
        end
        st_pre: begin
          if (timer_done && !timer_load) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      row_strobe_n_o        <= 1'b1;
      col_strobe_n_o        <= 1'b1;
      write_n_o             <= 1'b1;
      out_enable_n_o        <= 1'b1;
      multiplexed_address_o <= '0;
      data_lines_o          <= '0;
      data_lines_oe_o       <= 1'b0;
    end else begin
      row_strobe_n_o <= !((state == st_row) || (state == st_col) || (state == st_cbr_ras));
      // column strobe leads row strobe in refresh and counter test
      col_strobe_n_o <= !((state == st_col) || (state == st_cbr) || (state == st_cbr_ras));
      multiplexed_address_o <= (state == st_row) ? addr[2*ADDR_WIDTH-1:ADDR_WIDTH]
                                                 : addr[ADDR_WIDTH-1:0];
      // write strobe low with the column strobe gives an early write
      write_n_o <= !(is_write && (state == st_col));
      data_lines_o    <= wdata;
      data_lines_oe_o <= is_write && (state != st_idle) && (state != st_power);
      // never enable device outputs while we drive data
      out_enable_n_o  <= !(!is_write && (state == st_col));
    end
  end

  // ----------------------------------------------------------------
  // handshake and read data capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      init_done_o <= 1'b0;
    end else begin
      init_done_o <= (state != st_power) && (init_left == 4'h0);
      // no ready just before a refresh falls due, so a shown ready is honoured
      req_ready_o <= (state == st_idle) && timer_done && !timer_load &&
                     !refresh_due && (init_left == 4'h0) && !req_valid_i &&
                     (refresh_cnt != TW'(REFRESH_COUNT - 1));
      // sample after synchroniser delay; strobes stay low till then
      rsp_valid_o <= !is_write && timer_done && !timer_load && (state == st_col);
      if (!is_write && timer_done && !timer_load && (state == st_col)) begin
        rsp_rdata_o <= data_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_no_contention;
    @(posedge clk_i) disable iff (!reset_n_i)
      data_lines_oe_o |-> out_enable_n_o;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("output enable asserted while driving data");

  property p_row_before_col;
    @(posedge clk_i) disable iff (!reset_n_i)
      $fell(row_strobe_n_o) && col_strobe_n_o |=> col_strobe_n_o;
  endproperty
  a_row_before_col: assert property (p_row_before_col)
    else $error("column strobe fell with row strobe");

  property p_refresh_served;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(refresh_due) && init_done_o |-> ##[1:40] (state == st_cbr);
  endproperty
  a_refresh_served: assert property (p_refresh_served)
    else $error("refresh not started in time");

  property p_early_write;
    @(posedge clk_i) disable iff (!reset_n_i)
      $fell(col_strobe_n_o) && !row_strobe_n_o && is_write |-> !write_n_o;
  endproperty
  a_early_write: assert property (p_early_write)
    else $error("write strobe late for early write");

  property p_precharge;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(row_strobe_n_o) |-> row_strobe_n_o [*4];
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("row precharge too short");

  property p_no_access_before_init;
    @(posedge clk_i) disable iff (!reset_n_i)
      !init_done_o |-> !req_ready_o;
  endproperty
  a_no_access_before_init: assert property (p_no_access_before_init)
    else $error("access allowed before initialisation");
endmodule : dram_host_ctrl

/* verif/dram_device_model.sv */
`timescale 1ns/10ps
module dram_device_model
  import dram_ctrl_pkg::*;
#(
  parameter int CAS_ACCESS_NS = 50,
  parameter int RAS_ACCESS_NS = 100
) (
  input  wire logic [ADDR_WIDTH-1:0] addr_i,
  input  wire logic                  row_strobe_n_i,
  input  wire logic                  col_strobe_n_i,
  input  wire logic                  write_n_i,
  input  wire logic                  out_enable_n_i,
  input  wire logic [DATA_WIDTH-1:0] bus_i,
  output logic [DATA_WIDTH-1:0]      data_o,
  output logic                       drive_o,
  output logic [ADDR_WIDTH-1:0]      row_o,
  output int                         viol_count_o
);
  logic [DATA_WIDTH-1:0] mem [ROW_COUNT*ROW_COUNT];
  logic [ADDR_WIDTH-1:0] col = '0;
  logic [ADDR_WIDTH-1:0] counter = '0;
  logic                  cbr = 1'b0;
  logic                  test = 1'b0;
  logic                  ready = 1'b0;
  realtime               ras_fall = -1.0e9;
  realtime               test_fall = -1.0e9;
  int                    viol = 0;

  // ----------------------------------------------------------------
  // row strobe: external row or internal counter
  // ----------------------------------------------------------------
  always @(negedge row_strobe_n_i) begin
    if ($realtime - ras_fall < CYCLE_NS) viol++;
    ras_fall = $realtime;
    cbr = !col_strobe_n_i;
    test = 1'b0;
    if (cbr) begin
      row_o = counter;
      counter = counter + 1'b1;
    end else begin
      row_o = addr_i;
    end
  end

  always @(posedge row_strobe_n_i) begin
    if (test && $realtime - ras_fall < TEST_RAS_NS) viol++;
  end

  // ----------------------------------------------------------------
  // column strobe: access, also within a counter test cycle
  // ----------------------------------------------------------------
  always @(negedge col_strobe_n_i) begin
    ready = 1'b0;
    if (!row_strobe_n_i) begin
      col = addr_i;
      if (cbr && !test) begin
        test = 1'b1;
        if (ras_fall - test_fall < TEST_CYCLE_NS) viol++;
        test_fall = ras_fall;
      end
      if (!write_n_i) mem[{row_o, col}] = bus_i;
      #(CAS_ACCESS_NS);
      // data not valid before both access limits have run out
      while ($realtime - ras_fall < RAS_ACCESS_NS) #1;
      ready = !col_strobe_n_i;
    end
  end

  always @(negedge write_n_i) begin
    if (!row_strobe_n_i && !col_strobe_n_i) mem[{row_o, col}] = bus_i;
  end

  assign drive_o = !row_strobe_n_i && !col_strobe_n_i && write_n_i && !out_enable_n_i;
  assign data_o = ready ? mem[{row_o, col}] : ~mem[{row_o, col}];
  assign viol_count_o = viol;
endmodule : dram_device_model

/* verif/tb_dram_host_ctrl.sv */
`timescale 1ns/10ps
module tb_dram_host_ctrl;
  import dram_ctrl_pkg::*;
  localparam int POWER_UP = 50;
  localparam int REFRESH  = 200;
  localparam int CEILING  = 80000;

  logic                    clk_i;
  logic                    reset_n_i = 1'b0;
  logic                    req_valid_i = 1'b0;
  command_type             req_cmd_i = cmd_read;
  logic [2*ADDR_WIDTH-1:0] req_addr_i = '0;
  logic [DATA_WIDTH-1:0]   req_wdata_i = '0;
  logic                    req_ready_o, rsp_valid_o, init_done_o, dq_oe, m_drive;
  logic [DATA_WIDTH-1:0]   rsp_rdata_o, dq_o, m_data, bus, last_bus = '0;
  logic [ADDR_WIDTH-1:0]   mux_addr, m_row, acc_row;
  logic                    row_strobe_n, col_strobe_n, write_n, out_enable_n;
  int                      m_viol, clash = 0, ras_falls = 0, cycles = 0;
  int                      err_total = 0, check_count = 0;

  dram_host_ctrl #(.POWER_UP_COUNT(POWER_UP), .REFRESH_COUNT(REFRESH)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o),
    .multiplexed_address_o(mux_addr), .row_strobe_n_o(row_strobe_n),
    .col_strobe_n_o(col_strobe_n), .write_n_o(write_n), .out_enable_n_o(out_enable_n),
    .data_lines_i(bus), .data_lines_o(dq_o), .data_lines_oe_o(dq_oe));

  dram_device_model mdl_u (
    .addr_i(mux_addr), .row_strobe_n_i(row_strobe_n), .col_strobe_n_i(col_strobe_n),
    .write_n_i(write_n), .out_enable_n_i(out_enable_n), .bus_i(bus), .data_o(m_data),
    .drive_o(m_drive), .row_o(m_row), .viol_count_o(m_viol));

  // ----------------------------------------------------------------
  // shared data lines: a released bus keeps changing, never holds
  // ----------------------------------------------------------------
  always_comb bus = dq_oe ? dq_o : (m_drive ? m_data : ~last_bus);
  always @(posedge clk_i) last_bus <= bus;
  always @(negedge clk_i) if (dq_oe && (m_drive || !out_enable_n)) clash++;
  always @(negedge row_strobe_n) ras_falls++;
  always @(negedge col_strobe_n) if (!row_strobe_n) acc_row = m_row;

  initial begin
    clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == CEILING) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ready seen high means the next edge takes the request; valid stands one edge only
  task automatic request(input command_type cmd, input logic [15:0] addr,
                         input logic [3:0] wd, output logic [3:0] rd);
    int n;
    n = 0;
    rd = 'x;
    while (req_ready_o !== 1'b1 && n < 900) begin
      @(negedge clk_i);
      n++;
    end
    req_valid_i = 1'b1;
    req_cmd_i   = cmd;
    req_addr_i  = addr;
    req_wdata_i = wd;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    while ((cmd == cmd_read || cmd == cmd_test_read) && rsp_valid_o !== 1'b1 && n < 900) begin
      @(negedge clk_i);
      n++;
    end
    rd = rsp_rdata_o;
    check("request wait", 16'h0, 16'(n >= 900));
  endtask : request

  task automatic t_init();
    int n;
    int early;
    early = 0;
    for (n = 0; n < POWER_UP - 2; n++) begin
      @(negedge clk_i);
      if (row_strobe_n !== 1'b1) early++;
    end
    check("early strobe", 16'h0, 16'(early));
    n = 0;
    while (init_done_o !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    check("init refreshes", 16'h1, 16'(ras_falls >= INIT_REFRESHES));
    $display("test init done");
  endtask : t_init

  task automatic t_access();
    logic [15:0] addr [5];
    logic [3:0]  rd;
    addr = '{16'h0000, 16'hffff, 16'h00ff, 16'hff00, 16'h5aa5};
    foreach (addr[i]) request(cmd_write, addr[i], 4'(i + 3), rd);
    foreach (addr[i]) begin
      request(cmd_read, addr[i], 4'h0, rd);
      check("read back", 16'(4'(i + 3)), 16'(rd));
    end
    request(cmd_write, 16'h3cc3, 4'ha, rd);
    request(cmd_read, 16'h3cc3, 4'h0, rd);
    check("back to back", 16'ha, 16'(rd));
    $display("test access done");
  endtask : t_access

  task automatic t_refresh();
    int start;
    start = ras_falls;
    repeat (2000) @(negedge clk_i);
    check("refresh rate", 16'h1, 16'(ras_falls - start >= 2000 / REFRESH - 1));
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_counter();
    logic [3:0] rd;
    logic       hit [ROW_COUNT];
    int         hits;
    hits = 0;
    foreach (hit[r]) hit[r] = 1'b0;
    repeat (ROW_COUNT) begin
      request(cmd_test_write, 16'h0005, 4'h0, rd);
      hit[acc_row] = 1'b1;
    end
    foreach (hit[r]) hits += 32'(hit[r]);
    // interleaved refreshes advance the counter too: 40 cycles per op is generous
    check("rows walked", 16'h1, 16'(hits >= ROW_COUNT - ROW_COUNT * 40 / REFRESH));
    for (int r = 0; r < ROW_COUNT; r++) begin
      request(cmd_read, {8'(r), 8'h05}, 4'h0, rd);
      if (hit[r]) check("zero read", 16'h0, 16'(rd));
    end
    for (int r = 0; r < ROW_COUNT; r++) request(cmd_write, {8'(r), 8'h05}, 4'hf, rd);
    repeat (ROW_COUNT) begin
      request(cmd_test_read, 16'h0005, 4'h0, rd);
      check("one read", 16'hf, 16'(rd));
    end
    $display("test counter done");
  endtask : t_counter

  initial begin
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_init();
    t_access();
    t_refresh();
    t_counter();
    check("bus clash", 16'h0, 16'(clash));
    check("strobe timing", 16'h0, 16'(m_viol));
    print_verdict();
  end
endmodule : tb_dram_host_ctrl
